// file: logic/autoneg_next_page_regs.sv
// next page transmit and partner receive registers with management port
//
// Functional notes
// - transmit bit 15 next page flag, writable, resets to zero
// - transmit bit 13 message page flag, writable, resets to one
// - transmit bit 12 ACK2, writable, resets to zero
// - transmit bit 11 toggle, writable, resets to zero
// - receive bit 15 shows partner has more next pages
// - receive bit 14 shows partner acknowledged our code word
// - receive bit 13 shows partner message page flag
// - receive bit 12 shows partner ACK2 value
// - receive bit 11 shows partner toggle bit
// - receive bits 10:0 hold partner code field, reset zero
// - new page sets latching page received flag, read clears it
`include "np_regs_defines.svh"

module autoneg_next_page_regs (
  // clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                ce_i,
  // management register port
  input  wire np_regs_pkg::addr_t  reg_addr_i,
  input  wire np_regs_pkg::word_t  reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output np_regs_pkg::word_t       reg_rdata_o,
  // partner page from negotiation logic
  input  wire logic                lp_page_valid_i,
  input  wire np_regs_pkg::word_t  lp_page_i,
  // local page toward negotiation logic
  output np_regs_pkg::word_t       tx_page_o,
  output logic                     tx_page_load_o
);
  import np_regs_pkg::*;

  typedef struct packed {
    word_t rdata;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;

  acc_t  acc;
  logic  wr_tx;
  logic  rd_exp;
  word_t rx_page;
  logic  pg_flag;

  // access decode; write wins if a faulty master raises both
  always_comb begin
    if (reg_wr_i) begin
      acc = ACC_WR;
    end else if (reg_rd_i) begin
      acc = ACC_RD;
    end else begin
      acc = ACC_NONE;
    end
  end

  assign wr_tx  = (acc == ACC_WR) && (reg_addr_i == `NPR_OFS_TX);
  assign rd_exp = (acc == ACC_RD) && (reg_addr_i == `NPR_OFS_EXP);

  np_tx_page u_tx (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .wr_i    (wr_tx),
    .wdata_i (reg_wdata_i),
    .page_o  (tx_page_o),
    .load_o  (tx_page_load_o)
  );

  np_rx_page u_rx (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .valid_i (lp_page_valid_i),
    .word_i  (lp_page_i),
    .clr_i   (rd_exp),
    .page_o  (rx_page),
    .flag_o  (pg_flag)
  );

  // read data valid only in the cycle after the strobe, zero after other enabled cycles, held while enable is low
  always_comb begin
    st_nxt.rdata = '0;
    case (acc)
      ACC_RD: begin
        case (reg_addr_i)
          `NPR_OFS_EXP: begin
            // flag value before the clear of this same read
            st_nxt.rdata[`NPR_BIT_PGRX] = pg_flag;
          end
          `NPR_OFS_TX: begin
            st_nxt.rdata = tx_page_o;
          end
          `NPR_OFS_RX: begin
            st_nxt.rdata = rx_page;
          end
          default: begin
            st_nxt.rdata = '0;
          end
        endcase
      end
      ACC_WR: begin
        st_nxt.rdata = '0;
      end
      default: begin
        st_nxt.rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '{rdata: 16'h0000};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;

  // assertions

  property p_tx_rst;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(rstn_i) |-> (tx_page_o == `NPR_TX_RST);
  endproperty
  a_tx_rst: assert property (p_tx_rst)
    else $error("transmit page not at reset value");

  property p_np_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx)
      |=> (tx_page_o[`NPR_BIT_NP] == $past(reg_wdata_i[`NPR_BIT_NP]));
  endproperty
  a_np_wr: assert property (p_np_wr)
    else $error("next page flag not written");

  property p_mp_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx)
      |=> (tx_page_o[`NPR_BIT_MP] == $past(reg_wdata_i[`NPR_BIT_MP]));
  endproperty
  a_mp_wr: assert property (p_mp_wr)
    else $error("message page flag not written");

  property p_ack2_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx)
      |=> (tx_page_o[`NPR_BIT_ACK2] == $past(reg_wdata_i[`NPR_BIT_ACK2]));
  endproperty
  a_ack2_wr: assert property (p_ack2_wr)
    else $error("ack2 bit not written");

  property p_tgl_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx)
      |=> (tx_page_o[`NPR_BIT_TGL] == $past(reg_wdata_i[`NPR_BIT_TGL]));
  endproperty
  a_tgl_wr: assert property (p_tgl_wr)
    else $error("toggle bit not written");

  property p_code_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx)
      ##1 (ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == `NPR_OFS_TX))
      |=> (reg_rdata_o[`NPR_CODE_MSB:0] == $past(reg_wdata_i[`NPR_CODE_MSB:0], 2));
  endproperty
  a_code_rd: assert property (p_code_rd)
    else $error("code field read back differs");

  property p_rsvd;
    @(posedge clk_i) disable iff (!rstn_i)
      !tx_page_o[`NPR_BIT_ACK] && !(reg_rdata_o[`NPR_BIT_ACK] && $past(
        ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == `NPR_OFS_TX)));
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit 14 not zero");

  property p_rx_cap;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && lp_page_valid_i)
      ##1 (ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == `NPR_OFS_RX))
      |=> (reg_rdata_o == $past(lp_page_i, 2));
  endproperty
  a_rx_cap: assert property (p_rx_cap)
    else $error("received page not captured");

  property p_rx_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !(ce_i && lp_page_valid_i) |=> $stable(rx_page);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("received page changed without a page");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && lp_page_valid_i)
      ##1 (ce_i && rd_exp)
      |=> reg_rdata_o[`NPR_BIT_PGRX];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("page received flag not set");

  property p_flag_clr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && rd_exp && !lp_page_valid_i)
      ##1 (ce_i && rd_exp && !lp_page_valid_i)
      |=> !reg_rdata_o[`NPR_BIT_PGRX];
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("page received flag not cleared by read");

  property p_flag_race;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && rd_exp && lp_page_valid_i) |=> pg_flag;
  endproperty
  a_flag_race: assert property (p_flag_race)
    else $error("page lost in the clearing cycle");

  property p_load;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx) |=> tx_page_load_o;
  endproperty
  a_load: assert property (p_load)
    else $error("load pulse wrong");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && !(reg_rd_i && !reg_wr_i)) |=> (reg_rdata_o == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read answer");

  property p_freeze;
    @(posedge clk_i) disable iff (!rstn_i)
      !ce_i |=> ($stable(reg_rdata_o) && $stable(tx_page_o) && $stable(pg_flag));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  // a pulse frozen by a low enable must not be taken for a second write
  property p_load_end;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && !wr_tx) |=> !tx_page_load_o;
  endproperty
  a_load_end: assert property (p_load_end)
    else $error("load pulse without a write");

  property p_load_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !ce_i |=> $stable(tx_page_load_o);
  endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("load pulse moved while enable low");

  property p_tx_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !(ce_i && wr_tx) |=> $stable(tx_page_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit page changed without a write");

  property p_tx_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == `NPR_OFS_TX))
      |=> (reg_rdata_o == $past(tx_page_o));
  endproperty
  a_tx_rd: assert property (p_tx_rd)
    else $error("transmit page read back wrong");

  property p_rx_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i == `NPR_OFS_RX))
      |=> (reg_rdata_o == $past(rx_page));
  endproperty
  a_rx_rd: assert property (p_rx_rd)
    else $error("received page read back wrong");

  property p_exp_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && rd_exp) |=> (reg_rdata_o == {14'h0000, $past(pg_flag), 1'b0});
  endproperty
  a_exp_rd: assert property (p_exp_rd)
    else $error("flag register read back wrong");

  property p_other_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && reg_rd_i && !reg_wr_i && (reg_addr_i != `NPR_OFS_EXP)
        && (reg_addr_i != `NPR_OFS_TX) && (reg_addr_i != `NPR_OFS_RX))
      |=> (reg_rdata_o == 16'h0000);
  endproperty
  a_other_rd: assert property (p_other_rd)
    else $error("unmapped read not zero");

  property p_flag_keep;
    @(posedge clk_i) disable iff (!rstn_i)
      (pg_flag && !(ce_i && rd_exp)) |=> pg_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("page received flag dropped without a read");

  property p_flag_src;
    @(posedge clk_i) disable iff (!rstn_i)
      (!pg_flag && !(ce_i && lp_page_valid_i)) |=> !pg_flag;
  endproperty
  a_flag_src: assert property (p_flag_src)
    else $error("page received flag set without a page");

  property p_rst_vals;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(rstn_i) |-> (!tx_page_load_o && !pg_flag && (rx_page == `NPR_RX_RST)
        && (reg_rdata_o == 16'h0000));
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("receive side not at reset value");

  // covers

  property p_cv_tx_wr;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && wr_tx) ##1 tx_page_load_o;
  endproperty
  c_tx_wr: cover property (p_cv_tx_wr);

  property p_cv_rx_rd;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && lp_page_valid_i)
      ##[1:8] (ce_i && reg_rd_i && (reg_addr_i == `NPR_OFS_RX));
  endproperty
  c_rx_rd: cover property (p_cv_rx_rd);

  property p_cv_flag;
    @(posedge clk_i) disable iff (!rstn_i)
      (ce_i && lp_page_valid_i) ##1 (ce_i && rd_exp) ##1 reg_rdata_o[`NPR_BIT_PGRX];
  endproperty
  c_flag: cover property (p_cv_flag);

  property p_cv_race;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && rd_exp && lp_page_valid_i;
  endproperty
  c_race: cover property (p_cv_race);

endmodule : autoneg_next_page_regs

// file: pkg/np_regs_defines.svh
// offsets, field positions and reset values of the next page register bank
`ifndef NP_REGS_DEFINES_SVH
`define NP_REGS_DEFINES_SVH

`define NPR_OFS_EXP   5'h06
`define NPR_OFS_TX    5'h07
`define NPR_OFS_RX    5'h08

`define NPR_BIT_NP    15
`define NPR_BIT_ACK   14
`define NPR_BIT_MP    13
`define NPR_BIT_ACK2  12
`define NPR_BIT_TGL   11
`define NPR_CODE_MSB  10
`define NPR_BIT_PGRX  1

`define NPR_TX_RST    16'h2001
`define NPR_RX_RST    16'h0000
`define NPR_TX_WMASK  16'hBFFF

`endif

// file: pkg/np_regs_pkg.sv
// types shared by the next page register bank
package np_regs_pkg;

  typedef logic [15:0] word_t;
  typedef logic [4:0]  addr_t;

  typedef enum {
    ACC_NONE,
    ACC_RD,
    ACC_WR
  } acc_t;

endpackage : np_regs_pkg

// file: logic/np_tx_page.sv
// transmit next page register with load pulse toward the negotiation logic
`include "np_regs_defines.svh"

module np_tx_page (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // software write
  input  wire logic              wr_i,
  input  wire np_regs_pkg::word_t wdata_i,
  // toward link
  output np_regs_pkg::word_t     page_o,
  output logic                   load_o
);
  import np_regs_pkg::*;

  typedef struct packed {
    word_t page;
    logic  load;
  } tx_state_t;

  tx_state_t st_r;
  tx_state_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.load = 1'b0;
    if (wr_i) begin
      // bit 14 masked so it always reads zero
      st_nxt.page = wdata_i & `NPR_TX_WMASK;
      st_nxt.load = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '{page: `NPR_TX_RST, load: 1'b0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign page_o = st_r.page;
  assign load_o = st_r.load;

endmodule : np_tx_page

// file: logic/np_rx_page.sv
// partner next page capture with latching-high page received flag
`include "np_regs_defines.svh"

module np_rx_page (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // from link
  input  wire logic              valid_i,
  input  wire np_regs_pkg::word_t word_i,
  // software side
  input  wire logic              clr_i,
  output np_regs_pkg::word_t     page_o,
  output logic                   flag_o
);
  import np_regs_pkg::*;

  typedef struct packed {
    word_t page;
    logic  flag;
  } rx_state_t;

  rx_state_t st_r;
  rx_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr_i) begin
      st_nxt.flag = 1'b0;
    end
    // a page in the clearing cycle still sets the flag
    if (valid_i) begin
      st_nxt.page = word_i;
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '{page: `NPR_RX_RST, flag: 1'b0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign page_o = st_r.page;
  assign flag_o = st_r.flag;

endmodule : np_rx_page

// file: bench/lp_partner_model.sv
// link partner model: delivers partner pages, latches the local page on each load
module lp_partner_model (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // local page from the block
  input  wire np_regs_pkg::word_t tx_page_i,
  input  wire logic               tx_load_i,
  // partner page toward the block
  output logic                    valid_o,
  output np_regs_pkg::word_t      page_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import np_regs_pkg::*;

  word_t last_tx;

  initial begin
    valid_o = 1'b0;
    page_o  = 16'h0000;
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_tx <= 16'h0000;
    end else if (tx_load_i === 1'b1) begin
      last_tx <= tx_page_i;
    end
  end

  task automatic send(input word_t p);
    valid_o <= 1'b1;
    page_o  <= p;
    @(posedge clk_i);
  endtask : send

  // released lines show inverted data so a late sample cannot pass
  task automatic idle();
    valid_o <= 1'b0;
    page_o  <= ~page_o;
    @(posedge clk_i);
  endtask : idle
endmodule : lp_partner_model

// file: bench/autoneg_next_page_regs_tb.sv
// self-checking bench for the next page register bank
module autoneg_next_page_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import np_regs_pkg::*;

  logic  clk_i = 1'b0;
  logic  rstn_i, ce_i, reg_wr_i, reg_rd_i, lp_page_valid_i, tx_page_load_o;
  logic  rd_taken, rd_fresh, flag_m;
  addr_t reg_addr_i;
  word_t reg_wdata_i, reg_rdata_o, lp_page_i, tx_page_o, tx_m, rx_m, rnd, rd_hold;
  word_t exp_rd[$];
  word_t exp_tx[$];
  int    num_errors, tests_run;
  word_t pats[6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h07FF};

  always #10 clk_i = ~clk_i;

  autoneg_next_page_regs uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lp_page_valid_i(lp_page_valid_i), .lp_page_i(lp_page_i),
    .tx_page_o(tx_page_o), .tx_page_load_o(tx_page_load_o));

  lp_partner_model lp (
    .clk_i(clk_i), .rstn_i(rstn_i), .tx_page_i(tx_page_o), .tx_load_i(tx_page_load_o),
    .valid_o(lp_page_valid_i), .page_o(lp_page_i));

  task automatic check(input string name, input word_t e, input word_t s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // one bus cycle; the register model predicts what the read returns
  task automatic op(input logic ce, wr, rd, input addr_t a, input word_t d);
    ce_i        <= ce;
    reg_wr_i    <= wr;
    reg_rd_i    <= rd;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    if (ce && wr) begin
      if (a == 5'h07) begin
        tx_m = d & 16'hBFFF;
        exp_tx.push_back(tx_m);
      end
    end else if (ce && rd) begin
      exp_rd.push_back(a == 5'h07 ? tx_m : a == 5'h08 ? rx_m :
                       a == 5'h06 ? {14'h0000, flag_m, 1'b0} : 16'h0000);
      if (a == 5'h06) flag_m = 1'b0;
    end
    @(posedge clk_i);
  endtask : op

  // partner page, optionally colliding with a flag read, then read back
  task automatic page(input word_t p, input logic rd6);
    fork
      lp.send(p);
      op(1'b1, 1'b0, rd6, 5'h06, 16'h0000);
    join
    rx_m   = p;
    flag_m = 1'b1;
    fork
      lp.idle();
      op(1'b1, 1'b0, 1'b1, 5'h08, 16'h0000);
    join
  endtask : page

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_taken <= 1'b0;
      rd_fresh <= 1'b0;
    end else begin
      rd_taken <= reg_rd_i & ~reg_wr_i & ce_i;
      rd_fresh <= ce_i;
    end
  end

  // enable low holds the last answer, so the expectation is held as well
  always @(negedge clk_i) begin
    if (!rstn_i) rd_hold = 16'h0000;
    else if (rd_fresh && rd_taken) rd_hold = exp_rd.size() > 0 ? exp_rd.pop_front() : 16'hDEAD;
    else if (rd_fresh) rd_hold = 16'h0000;
    check("rdata", rd_hold, reg_rdata_o);
    if (rd_fresh && tx_page_load_o !== 1'b0)
      check("tx page", exp_tx.size() > 0 ? exp_tx.pop_front() : 16'hDEAD, tx_page_o);
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    conclude();
  end

  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, flag_m} = '0;
    ce_i = 1'b1;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
    tx_m = 16'h2001;
    rx_m = 16'h0000;
    num_errors = 0;
    tests_run = 0;
    rnd = word_t'($urandom(33));
    repeat (4) op(1, 0, 0, 5'h00, 0);
    check("tx reset", 16'h2001, tx_page_o);
    rstn_i <= 1'b1;
    op(1, 0, 1, 5'h07, 0);
    op(1, 0, 1, 5'h08, 0);
    op(1, 0, 1, 5'h06, 0);
    op(1, 0, 1, 5'h1F, 0);
    // read-only and unmapped writes must leave no trace
    op(1, 1, 0, 5'h08, 16'hFFFF);
    op(1, 1, 0, 5'h06, 16'hFFFF);
    op(1, 1, 0, 5'h1F, 16'hFFFF);
    op(1, 0, 1, 5'h08, 0);
    op(1, 0, 1, 5'h06, 0);
    for (int i = 0; i < 8; i++) begin
      rnd = (i < 6) ? pats[i] : word_t'($urandom());
      page(rnd, 1'b0);
      op(1, 0, 1, 5'h06, 0);
      op(1, 0, 1, 5'h06, 0);
      op(1, 1, 0, 5'h07, rnd ^ 16'h4800);
      op(1, 0, 1, 5'h07, 0);
    end
    op(1, 0, 0, 5'h00, 0);
    check("partner tx", tx_m, lp.last_tx);
    // write then read back with no gap
    op(1, 1, 0, 5'h07, 16'h5A5A);
    op(1, 0, 1, 5'h07, 0);
    fork
      lp.send(16'hAAAA);
      op(1, 0, 0, 5'h00, 0);
    join
    rx_m = 16'hAAAA;
    flag_m = 1'b1;
    page(16'h5555, 1'b1);
    page(16'h9999, 1'b1);
    op(1, 0, 1, 5'h06, 0);
    // frozen enable drops both a write and a page
    fork
      lp.send(16'h1111);
      op(1'b0, 1, 0, 5'h07, 16'hFFFF);
    join
    fork
      lp.idle();
      op(1'b0, 0, 1, 5'h08, 0);
    join
    op(1, 0, 1, 5'h08, 0);
    op(1, 0, 1, 5'h07, 0);
    op(1, 0, 1, 5'h06, 0);
    page(16'hF7FF, 1'b0);
    op(1, 1, 0, 5'h07, 16'hFFFF);
    op(1, 0, 0, 5'h00, 0);
    // reset in mid-run brings back the defaults
    rstn_i <= 1'b0;
    tx_m = 16'h2001;
    rx_m = 16'h0000;
    flag_m = 1'b0;
    repeat (4) op(1, 0, 0, 5'h00, 0);
    rstn_i <= 1'b1;
    op(1, 0, 1, 5'h07, 0);
    op(1, 0, 1, 5'h08, 0);
    op(1, 0, 1, 5'h06, 0);
    repeat (2) op(1, 0, 0, 5'h00, 0);
    check("queues", 16'h0000, word_t'(exp_rd.size() + exp_tx.size()));
    conclude();
  end
endmodule : autoneg_next_page_regs_tb
